// *** verilog/fcs_seek_config.sv ***
`timescale 1ns/1ps
module fcs_seek_config #(
  parameter int P_UNIT_CYC = fcs_pkg::UNIT_500K_CYC,
  // arbitrary value
  parameter logic [7:0] P_VERSION_BYTE = 8'hA5
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port
  input wire fcs_pkg::fcs_bus_req_t i_bus,
  output logic [7:0] o_rdata,
  // drive pins
  input wire fcs_pkg::fcs_drive_in_t i_drive,
  output fcs_pkg::fcs_drive_out_t o_drive,
  // transfer engine
  input wire logic i_rw_start,
  input wire logic [7:0] i_rw_cylinder,
  input wire logic i_rw_done,
  input wire logic i_xfer_need,
  output logic o_rw_go,
  output logic o_transfer_request_pin,
  output logic o_controller_interrupt,
  output fcs_pkg::fcs_queue_t o_queue
);
  import fcs_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    fcs_drive_in_t pin_meta;
    fcs_drive_in_t pin_sync;
    logic [1:0] cmd_cnt;
    logic [3:0][7:0] cmd_bytes;
    logic [1:0][7:0] res;
    logic [1:0] res_cnt;
    logic [7:0] rdata;
    fcs_cfg_t cfg;
    logic [2:0] rate;
    logic [7:0] present_cylinder;
    logic [7:0] st0;
    logic irq;
    logic xfer_irq;
    logic dreq;
    logic poll_pending;
    fcs_seek_e sk;
    fcs_kind_e kind;
    logic implied;
    logic first;
    logic [7:0] sk_arg;
    logic [6:0] recal_cnt;
    logic [31:0] sk_timer;
    fcs_head_e hd;
    logic [31:0] hd_timer;
    logic [7:0] rw_cyl;
    logic rw_go;
    fcs_drive_out_t drv;
  } fcs_state_t;

  fcs_state_t s;
  fcs_state_t next_s;

  // ****************************************
  // decoding and delays
  // ****************************************
  function automatic fcs_cmd_e decode(input logic [7:0] op);
    fcs_cmd_e c;
    c = CMD_INVALID;
    if ((op & OP_REL_MASK) == OP_REL_CODE)
      c = CMD_REL;
    else
    begin
      case (op)
        OP_SPECIFY: c = CMD_SPECIFY;
        OP_DRIVE_STATUS: c = CMD_DRIVE_STATUS;
        OP_RECAL: c = CMD_RECAL;
        OP_SENSE_IRQ: c = CMD_SENSE_IRQ;
        OP_SEEK: c = CMD_SEEK;
        OP_VERSION: c = CMD_VERSION;
        OP_CONFIGURE: c = CMD_CONFIGURE;
        default: c = CMD_INVALID;
      endcase
    end
    return c;
  endfunction

  function automatic logic [2:0] cmd_len(input fcs_cmd_e c);
    case (c)
      CMD_SPECIFY: return 3'h3;
      CMD_DRIVE_STATUS: return 3'h2;
      CMD_RECAL: return 3'h2;
      CMD_SEEK: return 3'h3;
      CMD_REL: return 3'h3;
      CMD_CONFIGURE: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction

  // cycles per delay unit at the selected rate
  function automatic logic [31:0] unit_cycles(input logic [2:0] rate);
    case (rate)
      RATE_2M: return 32'(P_UNIT_CYC / 4);
      RATE_1M: return 32'(P_UNIT_CYC / 2);
      RATE_300K: return 32'((P_UNIT_CYC * 5 + 2) / 3);
      RATE_250K: return 32'(P_UNIT_CYC * 2);
      default: return 32'(P_UNIT_CYC);
    endcase
  endfunction

  function automatic logic [31:0] delay(input logic [8:0] units,
                                        input logic [2:0] rate);
    logic [31:0] d;
    d = 32'(units) * unit_cycles(rate);
    if (d == 32'h0)
      d = 32'h1;
    return d;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    fcs_cmd_e cmd;
    logic [3:0][7:0] cb;
    logic start;
    fcs_kind_e start_kind;
    logic start_dir;
    logic [7:0] start_arg;
    logic start_implied;
    logic begin_load;
    logic done;
    logic fault;
    logic inward;
    logic [31:0] gap;
    logic [8:0] units;
    logic [7:0] v;
    next_s = s;
    cmd = CMD_INVALID;
    cb = s.cmd_bytes;
    start = 1'b0;
    start_kind = KIND_ABS;
    start_dir = 1'b0;
    start_arg = 8'h00;
    start_implied = 1'b0;
    begin_load = 1'b0;
    done = 1'b0;
    fault = 1'b0;
    inward = 1'b0;
    gap = 32'h0;
    units = 9'h000;
    v = 8'h00;

    next_s.pin_meta = i_drive;
    next_s.pin_sync = s.pin_meta;
    next_s.rw_go = 1'b0;
    next_s.rdata = 8'h00;
    next_s.dreq = ~s.cfg.no_dma_select & i_xfer_need;
    next_s.xfer_irq = s.cfg.no_dma_select & i_xfer_need;

    // register reads
    if (i_bus.rd)
    begin
      case (i_bus.addr)
        ADDR_STATUS:
        begin
          v[STAT_READY_BIT] = 1'b1;
          v[STAT_RESULT_BIT] = s.res_cnt != 2'h0;
          v[STAT_BUSY_BIT] = (s.cmd_cnt != 2'h0) || (s.res_cnt != 2'h0);
          v[STAT_HEAD_BIT] = s.drv.head_load;
          v[STAT_SEEK_BIT] = s.sk != SK_IDLE;
        end
        ADDR_DATA:
          if (s.res_cnt != 2'h0)
          begin
            v = s.res[0];
            next_s.res[0] = s.res[1];
            next_s.res_cnt = s.res_cnt - 2'h1;
          end
        ADDR_RATE: v = {5'h00, s.rate};
        ADDR_CYLINDER: v = s.present_cylinder;
        ADDR_CONFIG:
        begin
          v[CFG_AUTO_SEEK_BIT] = s.cfg.auto_seek_enable;
          v[CFG_QDIS_BIT] = s.cfg.queue_disable;
          v[CFG_POLLDIS_BIT] = s.cfg.poll_disable;
          v[3:0] = s.cfg.queue_threshold;
        end
        ADDR_PRECOMP: v = s.cfg.precomp_start_cylinder;
        ADDR_TIMING: v = {s.cfg.step_interval, s.cfg.head_unload_delay};
        default: v = 8'h00;
      endcase
      next_s.rdata = v;
    end

    // register writes; command bytes refused while results wait
    if (i_bus.wr && i_bus.addr == ADDR_RATE)
      next_s.rate = i_bus.wdata[2:0];
    if (i_bus.wr && i_bus.addr == ADDR_DATA && s.res_cnt == 2'h0)
    begin
      cb[s.cmd_cnt] = i_bus.wdata;
      next_s.cmd_bytes = cb;
      cmd = decode(cb[0]);
      if ({1'b0, s.cmd_cnt} + 3'h1 != cmd_len(cmd))
        next_s.cmd_cnt = s.cmd_cnt + 2'h1;
      else
      begin
        next_s.cmd_cnt = 2'h0;
        next_s.res_cnt = 2'h1;
        next_s.res[0] = ST0_INVALID;
        case (cmd)
          CMD_SPECIFY:
          begin
            next_s.res_cnt = 2'h0;
            next_s.cfg.step_interval = cb[1][7:4];
            next_s.cfg.head_unload_delay = cb[1][3:0];
            next_s.cfg.head_load_delay = cb[2][7:1];
            next_s.cfg.no_dma_select = cb[2][SPEC_NODMA_BIT];
          end
          CMD_DRIVE_STATUS:
            next_s.res[0] = {1'b0, s.pin_sync.write_protect,
                             s.pin_sync.ready, s.pin_sync.outer_stop_input,
                             s.pin_sync.two_side, cb[1][2:0]};
          CMD_CONFIGURE:
          begin
            next_s.res_cnt = 2'h0;
            next_s.cfg.auto_seek_enable = cb[2][CFG_AUTO_SEEK_BIT];
            next_s.cfg.queue_disable = cb[2][CFG_QDIS_BIT];
            next_s.cfg.poll_disable = cb[2][CFG_POLLDIS_BIT];
            next_s.cfg.queue_threshold = cb[2][3:0];
            next_s.cfg.precomp_start_cylinder = cb[3];
            if (cb[2][CFG_POLLDIS_BIT])
              next_s.poll_pending = 1'b0;
          end
          CMD_VERSION:
            next_s.res[0] = P_VERSION_BYTE;
          CMD_SENSE_IRQ:
            if (s.irq)
            begin
              next_s.res[0] = s.st0;
              next_s.res[1] = s.present_cylinder;
              next_s.res_cnt = 2'h2;
              next_s.irq = 1'b0;
            end
          CMD_SEEK, CMD_RECAL, CMD_REL:
            // one stepping engine: a second seek of any kind is refused
            if (s.sk == SK_IDLE)
            begin
              next_s.res_cnt = 2'h0;
              start = 1'b1;
              start_kind = (cmd == CMD_SEEK) ? KIND_ABS :
                           (cmd == CMD_REL) ? KIND_REL : KIND_RECAL;
              start_dir = cb[0][REL_DIR_BIT];
              start_arg = cb[2];
              next_s.drv.drive_sel = cb[1][1:0];
            end
          default: next_s.res[0] = ST0_INVALID;
        endcase
      end
    end

    // ****************************************
    // head load and unload
    // ****************************************
    case (s.hd)
      HD_IDLE:
        if (i_rw_start)
        begin
          next_s.rw_cyl = i_rw_cylinder;
          if (s.cfg.auto_seek_enable)
            next_s.hd = HD_SEEK_REQ;
          else
            begin_load = 1'b1;
        end
      HD_SEEK_REQ:
        if (s.sk == SK_IDLE && !start)
        begin
          if (s.rw_cyl != s.present_cylinder)
          begin
            start = 1'b1;
            start_kind = KIND_ABS;
            start_arg = s.rw_cyl;
            start_implied = 1'b1;
            next_s.hd = HD_SEEK_WAIT;
          end
          else
            begin_load = 1'b1;
        end
      HD_SEEK_WAIT:
        if (s.sk == SK_IDLE)
          begin_load = 1'b1;
      HD_LOAD:
        if (s.hd_timer == 32'h0)
        begin
          next_s.rw_go = 1'b1;
          next_s.hd = HD_ACTIVE;
        end
        else
          next_s.hd_timer = s.hd_timer - 32'h1;
      HD_ACTIVE:
        if (i_rw_done)
        begin
          units = (s.cfg.head_unload_delay == 4'h0) ? ZERO_CODE_UNITS :
            9'({s.cfg.head_unload_delay, 4'h0});
          next_s.hd_timer = delay(units, s.rate) - 32'h1;
          next_s.hd = HD_UNLOAD;
        end
      HD_UNLOAD:
        if (i_rw_start)
        begin
          next_s.rw_cyl = i_rw_cylinder;
          if (s.cfg.auto_seek_enable)
            next_s.hd = HD_SEEK_REQ;
          else
          begin
            next_s.rw_go = 1'b1;
            next_s.hd = HD_ACTIVE;
          end
        end
        else if (s.hd_timer == 32'h0)
        begin
          next_s.drv.head_load = 1'b0;
          next_s.hd = HD_IDLE;
        end
        else
          next_s.hd_timer = s.hd_timer - 32'h1;
      default: next_s.hd = HD_IDLE;
    endcase
    // a head still loaded skips the load wait
    if (begin_load)
    begin
      if (s.drv.head_load)
      begin
        next_s.rw_go = 1'b1;
        next_s.hd = HD_ACTIVE;
      end
      else
      begin
        units = (s.cfg.head_load_delay == 7'h00) ? ZERO_CODE_UNITS :
          9'({s.cfg.head_load_delay, 1'b0});
        next_s.drv.head_load = 1'b1;
        next_s.hd_timer = delay(units, s.rate) - 32'h1;
        next_s.hd = HD_LOAD;
      end
    end

    // ****************************************
    // polling interrupt after reset
    // ****************************************
    if (s.poll_pending && !s.cfg.poll_disable && s.hd == HD_IDLE)
    begin
      next_s.poll_pending = 1'b0;
      next_s.irq = 1'b1;
      next_s.st0 = {IC_POLL, 4'h0, s.drv.drive_sel};
    end

    // ****************************************
    // stepping engine
    // ****************************************
    case (s.sk)
      SK_IDLE:
        if (start)
        begin
          next_s.kind = start_kind;
          next_s.implied = start_implied;
          next_s.first = 1'b1;
          next_s.sk_arg = start_arg;
          next_s.recal_cnt = 7'h00;
          next_s.drv.direction = start_dir;
          if (start_kind == KIND_RECAL)
            next_s.present_cylinder = 8'h00;
          next_s.sk = SK_CHECK;
        end
      SK_CHECK:
      begin
        case (s.kind)
          KIND_ABS:
          begin
            done = s.present_cylinder == s.sk_arg;
            inward = s.present_cylinder < s.sk_arg;
          end
          KIND_REL:
          begin
            done = s.sk_arg == 8'h00;
            inward = s.drv.direction;
            fault = !done && !inward && s.pin_sync.outer_stop_input;
          end
          default:
          begin
            done = s.pin_sync.outer_stop_input;
            fault = !done && s.recal_cnt == RECAL_MAX_STEPS;
          end
        endcase
        if (done || fault)
        begin
          if (!s.implied)
          begin
            next_s.irq = 1'b1;
            next_s.st0 = {fault ? IC_ABNORMAL : IC_NORMAL, 4'h0,
                          s.drv.drive_sel};
            next_s.st0[ST0_SE_BIT] = 1'b1;
            next_s.st0[ST0_EC_BIT] = fault;
          end
          next_s.sk = SK_IDLE;
        end
        else
        begin
          // direction and step rise together; drives latch on the edge
          next_s.drv.direction = inward;
          next_s.drv.step = 1'b1;
          next_s.sk_timer = 32'(STEP_PULSE_CYC - 1);
          next_s.sk = SK_PULSE;
          if (s.kind == KIND_RECAL)
            next_s.recal_cnt = s.recal_cnt + 7'h01;
          else
            next_s.present_cylinder = inward ? s.present_cylinder + 8'h01
              : s.present_cylinder - 8'h01;
          if (s.kind == KIND_REL)
            next_s.sk_arg = s.sk_arg - 8'h01;
        end
      end
      SK_PULSE:
        if (s.sk_timer == 32'h0)
        begin
          next_s.drv.step = 1'b0;
          gap = delay({4'h0, STEP_UNITS_TOP - {1'b0, s.cfg.step_interval}},
                      s.rate);
          if (s.first)
            gap = gap >> 1;
          next_s.sk_timer = (gap == 32'h0) ? 32'h0 : gap - 32'h1;
          next_s.first = 1'b0;
          next_s.sk = SK_WAIT;
        end
        else
          next_s.sk_timer = s.sk_timer - 32'h1;
      SK_WAIT:
        if (s.sk_timer == 32'h0)
          next_s.sk = SK_CHECK;
        else
          next_s.sk_timer = s.sk_timer - 32'h1;
      default: next_s.sk = SK_IDLE;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      s <= '0;
      s.cfg <= CFG_RESET;
      s.rate <= RATE_RESET;
      s.poll_pending <= 1'b1;
      s.sk <= SK_IDLE;
      s.hd <= HD_IDLE;
      s.kind <= KIND_ABS;
    end
    else
      s <= next_s;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_rdata = s.rdata;
  assign o_drive = s.drv;
  assign o_rw_go = s.rw_go;
  assign o_transfer_request_pin = s.dreq;
  assign o_controller_interrupt = s.irq | s.xfer_irq;
  assign o_queue.enable = ~s.cfg.queue_disable;
  assign o_queue.threshold = s.cfg.queue_disable ? QUEUE_MIN_BYTES :
    {1'b0, s.cfg.queue_threshold} + QUEUE_MIN_BYTES;
  assign o_queue.precomp_start_cylinder = s.cfg.precomp_start_cylinder;

endmodule // fcs_seek_config

// *** verilog/fcs_pkg.sv ***
package fcs_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  // one delay unit is 1 ms at 500 kbps and scales inversely with the data rate
  localparam int UNIT_500K_NS = 1000000;
  localparam int UNIT_500K_CYC = UNIT_500K_NS / CLK_PERIOD_NS;
  localparam int STEP_PULSE_NS = 1000;
  localparam int STEP_PULSE_CYC =
    (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] STEP_UNITS_TOP = 5'h10;
  localparam logic [8:0] ZERO_CODE_UNITS = 9'h100;
  localparam int UNLOAD_SHIFT = 4;
  localparam int LOAD_SHIFT = 1;
  localparam logic [6:0] RECAL_MAX_STEPS = 7'h50;

  // ****************************************
  // data rates
  // ****************************************
  localparam logic [2:0] RATE_500K = 3'h0;
  localparam logic [2:0] RATE_300K = 3'h1;
  localparam logic [2:0] RATE_250K = 3'h2;
  localparam logic [2:0] RATE_1M = 3'h3;
  localparam logic [2:0] RATE_2M = 3'h4;
  localparam logic [2:0] RATE_RESET = RATE_500K;

  // ****************************************
  // register port map
  // ****************************************
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_RATE = 3'h2;
  localparam logic [2:0] ADDR_CYLINDER = 3'h3;
  localparam logic [2:0] ADDR_CONFIG = 3'h4;
  localparam logic [2:0] ADDR_PRECOMP = 3'h5;
  localparam logic [2:0] ADDR_TIMING = 3'h6;
  localparam int STAT_SEEK_BIT = 0;
  localparam int STAT_HEAD_BIT = 1;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_RESULT_BIT = 6;
  localparam int STAT_READY_BIT = 7;

  // ****************************************
  // commands and fields
  // ****************************************
  localparam logic [7:0] OP_SPECIFY = 8'h03;
  localparam logic [7:0] OP_DRIVE_STATUS = 8'h04;
  localparam logic [7:0] OP_RECAL = 8'h07;
  localparam logic [7:0] OP_SENSE_IRQ = 8'h08;
  localparam logic [7:0] OP_SEEK = 8'h0F;
  localparam logic [7:0] OP_VERSION = 8'h10;
  localparam logic [7:0] OP_CONFIGURE = 8'h13;
  localparam logic [7:0] OP_REL_MASK = 8'hBF;
  localparam logic [7:0] OP_REL_CODE = 8'h8F;
  localparam int REL_DIR_BIT = 6;
  localparam int SPEC_NODMA_BIT = 0;
  localparam int CFG_AUTO_SEEK_BIT = 6;
  localparam int CFG_QDIS_BIT = 5;
  localparam int CFG_POLLDIS_BIT = 4;
  localparam int ST0_SE_BIT = 5;
  localparam int ST0_EC_BIT = 4;
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_POLL = 2'h3;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [4:0] QUEUE_MIN_BYTES = 5'h01;

  typedef enum logic [3:0] {
    CMD_SPECIFY, CMD_DRIVE_STATUS, CMD_RECAL, CMD_SENSE_IRQ, CMD_SEEK,
    CMD_VERSION, CMD_CONFIGURE, CMD_REL, CMD_INVALID
  } fcs_cmd_e;
  typedef enum logic [1:0] {KIND_ABS, KIND_REL, KIND_RECAL} fcs_kind_e;
  typedef enum logic [1:0] {SK_IDLE, SK_CHECK, SK_PULSE, SK_WAIT} fcs_seek_e;
  typedef enum logic [2:0] {
    HD_IDLE, HD_SEEK_REQ, HD_SEEK_WAIT, HD_LOAD, HD_ACTIVE, HD_UNLOAD
  } fcs_head_e;

  typedef struct packed {
    logic [3:0] step_interval;
    logic [3:0] head_unload_delay;
    logic [6:0] head_load_delay;
    logic no_dma_select;
    logic auto_seek_enable;
    logic queue_disable;
    logic poll_disable;
    logic [3:0] queue_threshold;
    logic [7:0] precomp_start_cylinder;
  } fcs_cfg_t;

  localparam fcs_cfg_t CFG_RESET = '{
    step_interval: 4'h0, head_unload_delay: 4'h0, head_load_delay: 7'h00,
    no_dma_select: 1'b0, auto_seek_enable: 1'b0, queue_disable: 1'b1,
    poll_disable: 1'b0, queue_threshold: 4'h0,
    precomp_start_cylinder: 8'h00};

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fcs_bus_req_t;

  typedef struct packed {
    logic outer_stop_input;
    logic write_protect;
    logic ready;
    logic two_side;
  } fcs_drive_in_t;

  typedef struct packed {
    logic step;
    logic direction;
    logic head_load;
    logic [1:0] drive_sel;
  } fcs_drive_out_t;

  typedef struct packed {
    logic enable;
    logic [4:0] threshold;
    logic [7:0] precomp_start_cylinder;
  } fcs_queue_t;

endpackage

// *** verification/fcs_seek_config_props.sv ***
`timescale 1ns/1ps
module fcs_seek_config_props
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port
  input wire fcs_pkg::fcs_bus_req_t i_bus,
  input wire logic [7:0] o_rdata,
  // drive pins
  input wire fcs_pkg::fcs_drive_in_t i_drive,
  input wire fcs_pkg::fcs_drive_out_t o_drive,
  // transfer engine
  input wire logic i_rw_start,
  input wire logic [7:0] i_rw_cylinder,
  input wire logic i_rw_done,
  input wire logic i_xfer_need,
  input wire logic o_rw_go,
  input wire logic o_transfer_request_pin,
  input wire logic o_controller_interrupt,
  input wire fcs_pkg::fcs_queue_t o_queue
);
  import fcs_pkg::*;
  logic [8:0] hi_cnt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ****
  // checks
  // ****
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !o_drive.step)
      hi_cnt <= 9'h000;
    else
      hi_cnt <= hi_cnt + 9'h001;
  end
  a_step_width: assert property ($fell(o_drive.step) |->
    hi_cnt == 9'(STEP_PULSE_CYC)) else $error("bad step width");
  a_step_gap: assert property ($fell(o_drive.step) |->
    !o_drive.step [*3]) else $error("step gap short");
  a_dir_steady: assert property (o_drive.step &&
    $past(o_drive.step) |-> $stable(o_drive.direction))
    else $error("direction moved in pulse");
  a_dma_cause: assert property ($rose(o_transfer_request_pin) |->
    $past(i_xfer_need)) else $error("request without need");
  a_thr_range: assert property (
    o_queue.threshold inside {[5'h01:5'h10]}) else $error("bad threshold");
  a_reset_cfg: assert property ($past(i_sys_rst) |->
    o_queue == {1'b0, 5'h01, 8'h00}) else $error("bad queue default");
  a_go_loaded: assert property (o_rw_go |-> o_drive.head_load)
    else $error("go while unloaded");
  a_load_wait: assert property ($rose(o_drive.head_load) |->
    !o_rw_go ##1 !o_rw_go) else $error("go without load wait");
  a_precomp_src: assert property (
    $changed(o_queue.precomp_start_cylinder) |-> $past(i_bus.wr) ||
    $past(i_bus.wr, 2) || $past(i_bus.wr, 3)) else $error("precomp moved");
endmodule // fcs_seek_config_props

bind fcs_seek_config fcs_seek_config_props i_fcs_seek_config_props (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_drive(i_drive), .o_drive(o_drive), .i_rw_start(i_rw_start),
  .i_rw_cylinder(i_rw_cylinder), .i_rw_done(i_rw_done),
  .i_xfer_need(i_xfer_need), .o_rw_go(o_rw_go),
  .o_transfer_request_pin(o_transfer_request_pin),
  .o_controller_interrupt(o_controller_interrupt), .o_queue(o_queue));

// *** verification/fcs_drive_model.sv ***
`timescale 1ns/1ps
module fcs_drive_model
(
  // clock
  input wire logic i_clk,
  // drive pins
  input wire fcs_pkg::fcs_drive_out_t i_drive,
  output fcs_pkg::fcs_drive_in_t o_drive
);
  import fcs_pkg::*;
  int track = 0;
  logic step_q = 1'b0;
  // ****
  // head mechanics
  // ****
  // past the outer stop the head cannot move further out
  always @(posedge i_clk)
  begin
    if (i_drive.step && !step_q && i_drive.direction)
      track <= track + 1;
    else if (i_drive.step && !step_q && track > 0)
      track <= track - 1;
    step_q <= i_drive.step;
  end
  assign o_drive = '{track == 0, 1'b0, 1'b1, 1'b1};
endmodule // fcs_drive_model

// *** verification/tb_fcs_seek_config.sv ***
`timescale 1ns/1ps
module tb_fcs_seek_config;
  import fcs_pkg::*;
  // arbitrary value
  localparam logic [7:0] VER = 8'h5A;
  logic i_clk = 1'b0;
  logic rst = 1'b1;
  fcs_bus_req_t bus = '0;
  fcs_drive_in_t din;
  fcs_drive_out_t dout;
  fcs_queue_t q;
  logic start = 1'b0;
  logic done = 1'b0;
  logic need = 1'b0;
  logic [7:0] cyl = 8'h00;
  logic [7:0] rdata;
  logic go, dreq, irq, dir;
  logic sq = 1'b0;
  int fail_count = 0;
  int checks = 0;
  int nst = 0;
  int n;
  fcs_seek_config #(.P_UNIT_CYC(20), .P_VERSION_BYTE(VER)) i_fcs_seek_config (
    .i_clk(i_clk), .i_sys_rst(rst), .i_bus(bus), .o_rdata(rdata),
    .i_drive(din), .o_drive(dout), .i_rw_start(start),
    .i_rw_cylinder(cyl), .i_rw_done(done), .i_xfer_need(need),
    .o_rw_go(go), .o_transfer_request_pin(dreq),
    .o_controller_interrupt(irq), .o_queue(q));
  fcs_drive_model i_fcs_drive_model (.i_clk(i_clk), .i_drive(dout),
    .o_drive(din));
  // ****
  // clock, step monitor, helpers
  // ****
  initial
  begin
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    if (dout.step && !sq)
    begin
      nst++;
      dir = dout.direction;
    end
    sq <= dout.step;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic pulse(input logic is_done);
    @(posedge i_clk);
    if (is_done)
      done <= 1'b1;
    else
      start <= 1'b1;
    @(posedge i_clk);
    start <= 1'b0;
    done <= 1'b0;
    #1;
  endtask
  task automatic seek(input logic [7:0] op, c, st0, pc, ns, input logic d);
    int n0;
    n0 = nst;
    n = 0;
    wr(ADDR_DATA, op);
    wr(ADDR_DATA, 8'h01);
    if (op != OP_RECAL)
      wr(ADDR_DATA, c);
    while (irq !== 1'b1 && n < 60000)
    begin
      @(posedge i_clk);
      n++;
    end
    #1;
    chk({7'h00, irq}, 8'h01);
    chk(8'(nst - n0), ns);
    chk({7'h00, dir}, {7'h00, d});
    chk({6'h00, dout.drive_sel}, 8'h01);
    wr(ADDR_DATA, OP_SENSE_IRQ);
    rd(ADDR_DATA, st0);
    rd(ADDR_DATA, pc);
    $display("test seek %h end", op);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    repeat (4) @(posedge i_clk);
    #1;
    chk({7'h00, irq}, 8'h01);
    chk({q.enable, 2'b00, q.threshold}, 8'h01);
    chk(q.precomp_start_cylinder, 8'h00);
    rd(ADDR_CONFIG, 8'h20);
    wr(ADDR_DATA, OP_SENSE_IRQ);
    rd(ADDR_DATA, 8'hC0);
    rd(ADDR_DATA, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_DATA, OP_DRIVE_STATUS);
    wr(ADDR_DATA, 8'h01);
    rd(ADDR_DATA, 8'h39);
    wr(ADDR_DATA, OP_VERSION);
    rd(ADDR_DATA, VER);
    wr(ADDR_DATA, 8'hFF);
    rd(ADDR_DATA, ST0_INVALID);
    rd(3'h7, 8'h00);
    $display("test reset end");
  endtask
  task automatic t_xfer();
    wr(ADDR_DATA, OP_SPECIFY);
    wr(ADDR_DATA, 8'hF1);
    wr(ADDR_DATA, 8'h02);
    rd(ADDR_TIMING, 8'hF1);
    pulse(1'b0);
    chk({7'h00, dout.head_load}, 8'h01);
    n = 0;
    while (go !== 1'b1 && n < 500)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk(8'((n + 5) / 10), 8'h04);
    @(posedge i_clk);
    need <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    chk({6'h00, dreq, irq}, 8'h02);
    @(posedge i_clk);
    need <= 1'b0;
    pulse(1'b1);
    n = 0;
    while (dout.head_load === 1'b1 && n < 1000)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk(8'((n + 5) / 10), 8'h20);
    wr(ADDR_DATA, OP_SPECIFY);
    wr(ADDR_DATA, 8'hF1);
    wr(ADDR_DATA, 8'h03);
    @(posedge i_clk);
    need <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    chk({6'h00, dreq, irq}, 8'h01);
    @(posedge i_clk);
    need <= 1'b0;
    $display("test transfer end");
  endtask
  task automatic t_config();
    wr(ADDR_DATA, OP_CONFIGURE);
    wr(ADDR_DATA, 8'h00);
    wr(ADDR_DATA, 8'h4F);
    wr(ADDR_DATA, 8'hFF);
    rd(ADDR_CONFIG, 8'h4F);
    chk({q.enable, 2'b00, q.threshold}, 8'h90);
    chk(q.precomp_start_cylinder, 8'hFF);
    n = nst;
    @(posedge i_clk);
    cyl <= 8'h05;
    pulse(1'b0);
    while (go !== 1'b1 && nst - n < 9)
      @(posedge i_clk);
    chk(8'(nst - n), 8'h05);
    pulse(1'b1);
    $display("test config end");
  endtask
  // ****
  // run
  // ****
  initial
  begin
    repeat (10) @(posedge i_clk);
    rst <= 1'b0;
    t_reset();
    t_xfer();
    t_config();
    seek(8'hCF, 8'h03, 8'h21, 8'h08, 8'h03, 1'b1);
    seek(8'h8F, 8'h0A, 8'h71, 8'h00, 8'h08, 1'b0);
    seek(OP_SEEK, 8'h02, 8'h21, 8'h02, 8'h02, 1'b1);
    seek(8'hCF, 8'hFF, 8'h21, 8'h01, 8'hFF, 1'b1);
    seek(8'h8F, 8'h02, 8'h21, 8'hFF, 8'h02, 1'b0);
    seek(OP_SEEK, 8'hFE, 8'h21, 8'hFE, 8'h01, 1'b0);
    seek(OP_RECAL, 8'h00, 8'h71, 8'h00, 8'h50, 1'b0);
    tally_and_finish();
  end
  initial
  begin
    repeat (100000) @(posedge i_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule // tb_fcs_seek_config
